// ==== sprwc_pin_reset_wake.sv ====
// Behaviour
// - Regulator off in sleep, on otherwise
// - Supply enable driven high or floating only
// - Supply enable high in normal, standby; released sleeping
// - Any wake event raises supply enable
// - Wake event in sleep or standby pulls receive output low
// - Local wake input reacts to both edges
// - Reset line driven low in fail-safe
// - Power-up, sleep, fail-safe exit, undervoltage: cold hold
// - Long external low pulse in normal or standby enters reset mode
// - External pulse or watchdog error: warm hold
// - Serial output driven only while selected
// - Serial access only while selected and clocked
// - Serial input accepted only while selected
// - Cold hold lasts 20 to 27 ms
// - Warm hold lasts 1 to 1.5 ms
`timescale 1ns/1ps

module sprwc_pin_reset_wake
	import sprwc_pkg::*;
#(
	parameter int unsigned COLD_CYC = COLD_HOLD_CYC,
	parameter int unsigned WARM_CYC = WARM_HOLD_CYC
) (
	input wire logic I_CLOCK,
	input wire logic I_SYS_RST,
	// Pins from the outside world
	input wire logic I_WAKE,
	input wire logic I_RST_LINE,
	input wire logic I_CS_N,
	input wire logic I_SCLK,
	input wire logic I_SDI,
	// Analog supervisors, asynchronous to the clock
	input wire logic I_UNDERVOLT,
	input wire logic I_OVERVOLT,
	input wire logic I_OVERTEMP,
	// Internal logic on the same clock
	input wire logic I_BUS_WAKE,
	input wire logic I_WDT_ERR,
	input wire logic I_MODE_REQ_VLD,
	input wire logic [MODE_REQ_W-1:0] I_MODE_REQ,
	input wire logic I_BUS_RXD,
	input wire logic I_SDO_BIT,
	// Pin outputs
	output logic O_SUPPLY_EN,
	output logic O_SUPPLY_EN_OE,
	output logic O_REG_EN,
	output logic O_RXD,
	output logic O_RST_LINE,
	output logic O_RST_LINE_OE,
	output logic O_SDO,
	output logic O_SDO_OE,
	// Towards the internal serial logic and status
	output logic O_SDI_BIT,
	output logic O_SDI_VLD,
	output logic O_SDO_SHIFT,
	output logic O_SPI_SEL,
	output logic [5:0] O_MODE,
	output logic O_WAKE_PEND
);
	// Decide whether a mode keeps the system powered
	function automatic logic mode_powered(input sprwc_mode_t m);
		return (m != MODE_SLEEP);
	endfunction : mode_powered

	// Modes where the far side may request a reset by pulse
	function automatic logic mode_pulse_ok(input sprwc_mode_t m);
		return (m == MODE_NORMAL) || (m == MODE_STANDBY);
	endfunction : mode_pulse_ok

	logic [PIN_W-1:0] pin_lvl, pin_rise, pin_fall;
	logic [2:0] sup_lvl;
	logic uv, ov, ot;

	// Every pin passes two flops before use
	sprwc_pin_sync #(
		.W(PIN_W),
		.RST_VAL(PIN_IDLE)
	) u_pin_sync (
		.i_clk(I_CLOCK),
		.i_rst(I_SYS_RST),
		.i_pin({I_SDI, I_SCLK, I_CS_N, I_RST_LINE, I_WAKE}),
		.o_lvl(pin_lvl),
		.o_rise(pin_rise),
		.o_fall(pin_fall)
	);

	// Supervisor levels are slow; edges are unused
	sprwc_pin_sync #(
		.W(3),
		.RST_VAL(3'h0)
	) u_sup_sync (
		.i_clk(I_CLOCK),
		.i_rst(I_SYS_RST),
		.i_pin({I_OVERTEMP, I_OVERVOLT, I_UNDERVOLT}),
		.o_lvl(sup_lvl),
		.o_rise(),
		.o_fall()
	);

	assign uv = sup_lvl[0];
	assign ov = sup_lvl[1];
	assign ot = sup_lvl[2];

	sprwc_tmr_if tmr_if ();

	sprwc_hold_tmr u_hold_tmr (
		.i_clk(I_CLOCK),
		.i_rst(I_SYS_RST),
		.tif(tmr_if.tmr)
	);

	// Mode control state
	sprwc_mode_t mode_r, mode_nxt;
	logic por_r, por_nxt;
	logic wake_r, wake_nxt;
	logic [LOW_CNT_W-1:0] low_r, low_nxt;
	logic local_wake, any_wake, ext_pulse, rst_drv_r;
	logic cold_req, warm_req;

	// Either edge of the wake pin counts by default
	assign local_wake = pin_rise[PIN_WAKE] | pin_fall[PIN_WAKE];
	assign any_wake = (local_wake | I_BUS_WAKE) &&
		((mode_r == MODE_SLEEP) || (mode_r == MODE_STANDBY));

	// Long low on the line while we do not drive it is a request
	assign ext_pulse = (low_r == LOW_CNT_TRIP);

	// Cold and warm crank causes, undervoltage first
	assign cold_req = por_r || uv || ((mode_r == MODE_SLEEP) && any_wake);
	assign warm_req = ext_pulse || (I_WDT_ERR && (mode_r != MODE_SLEEP) &&
		(mode_r != MODE_RESET) && (mode_r != MODE_FAILSAFE));

	// Next mode and hold timer load
	always_comb begin
		mode_nxt = mode_r;
		por_nxt = 1'b0;
		tmr_if.load = 1'b0;
		tmr_if.load_val = HOLD_CNT_W'(COLD_CYC);
		if (cold_req) begin
			// Power-up, sleep exit, undervoltage: cold hold
			mode_nxt = MODE_RESET;
			tmr_if.load = 1'b1;
		end else if (ov || ot) begin
			mode_nxt = MODE_FAILSAFE;
		end else if (mode_r == MODE_FAILSAFE) begin
			// Leaving fail-safe for reset is a cold crank
			mode_nxt = MODE_RESET;
			tmr_if.load = 1'b1;
		end else if (warm_req) begin
			mode_nxt = MODE_RESET;
			tmr_if.load = 1'b1;
			tmr_if.load_val = HOLD_CNT_W'(WARM_CYC);
		end else begin
			unique case (mode_r)
				MODE_RESET: begin
					// Leave only once the hold ended and nobody holds the line
					if (!tmr_if.busy && !rst_drv_r && pin_lvl[PIN_RST]) begin
						mode_nxt = MODE_STANDBY;
					end
				end
				MODE_SLEEP: begin
					mode_nxt = MODE_SLEEP;
				end
				MODE_NORMAL, MODE_SILENT, MODE_STANDBY: begin
					if (I_MODE_REQ_VLD) begin
						unique case (I_MODE_REQ)
							REQ_NORMAL: mode_nxt = MODE_NORMAL;
							REQ_SILENT: mode_nxt = MODE_SILENT;
							REQ_STANDBY: mode_nxt = MODE_STANDBY;
							REQ_SLEEP: mode_nxt = MODE_SLEEP;
						endcase
					end
				end
				default: begin
					mode_nxt = MODE_RESET;
				end
			endcase
		end
	end

	// Wake flag and pulse counter
	always_comb begin
		wake_nxt = wake_r;
		// Cleared once the controller has brought the part to normal
		if (mode_r == MODE_NORMAL) begin
			wake_nxt = 1'b0;
		end
		// A new wake wins over the clear
		if (any_wake) begin
			wake_nxt = 1'b1;
		end
		low_nxt = '0;
		if (mode_pulse_ok(mode_r) && !rst_drv_r && !pin_lvl[PIN_RST] && !ext_pulse) begin
			low_nxt = low_r + LOW_CNT_W'(1);
		end
	end

	// Sync reset lands in reset mode with a power-up cold crank pending
	always_ff @(posedge I_CLOCK) begin
		if (I_SYS_RST) begin
			mode_r <= MODE_RESET;
			por_r <= 1'b1;
			wake_r <= 1'b0;
			low_r <= '0;
		end else begin
			mode_r <= mode_nxt;
			por_r <= por_nxt;
			wake_r <= wake_nxt;
			low_r <= low_nxt;
		end
	end

	// Pin output state, registered from the next mode, the hold timer and the wake flag
	logic sup_oe_r, sup_oe_nxt;
	logic reg_en_r, reg_en_nxt;
	logic rst_drv_nxt;
	logic rxd_r, rxd_nxt;

	always_comb begin
		// Enable pin is only ever pulled up or released
		sup_oe_nxt = mode_powered(mode_nxt);
		// Regulator gated in sleep, back on in every other mode
		reg_en_nxt = mode_powered(mode_nxt);
		// Low during hold and in fail-safe
		rst_drv_nxt = (mode_nxt == MODE_FAILSAFE) ||
			((mode_nxt == MODE_RESET) && (tmr_if.load || tmr_if.busy));
		// Pending wake overrides bus data on the receive pin
		rxd_nxt = wake_nxt ? 1'b0 : I_BUS_RXD;
	end

	always_ff @(posedge I_CLOCK) begin
		if (I_SYS_RST) begin
			sup_oe_r <= 1'b0;
			reg_en_r <= 1'b0;
			rst_drv_r <= 1'b1;
			rxd_r <= 1'b1;
		end else begin
			sup_oe_r <= sup_oe_nxt;
			reg_en_r <= reg_en_nxt;
			rst_drv_r <= rst_drv_nxt;
			rxd_r <= rxd_nxt;
		end
	end

	// Serial port gating; the clock is sampled, so its rate must stay low
	logic sel;
	logic sdo_r, sdo_nxt;
	logic sdo_oe_r, sdo_oe_nxt;
	logic sdi_r, sdi_nxt;
	logic sdi_vld_r, sdi_vld_nxt;
	logic shift_r, shift_nxt;

	assign sel = !pin_lvl[PIN_CS_N];

	always_comb begin
		// Data in only on a rising clock while selected
		sdi_vld_nxt = sel && pin_rise[PIN_SCLK];
		sdi_nxt = sdi_vld_nxt ? pin_lvl[PIN_SDI] : sdi_r;
		// Data out changes on the falling clock while selected
		shift_nxt = sel && pin_fall[PIN_SCLK];
		sdo_nxt = shift_nxt ? I_SDO_BIT : sdo_r;
		// Output floats whenever deselected
		sdo_oe_nxt = sel;
	end

	always_ff @(posedge I_CLOCK) begin
		if (I_SYS_RST) begin
			sdo_r <= 1'b0;
			sdo_oe_r <= 1'b0;
			sdi_r <= 1'b0;
			sdi_vld_r <= 1'b0;
			shift_r <= 1'b0;
		end else begin
			sdo_r <= sdo_nxt;
			sdo_oe_r <= sdo_oe_nxt;
			sdi_r <= sdi_nxt;
			sdi_vld_r <= sdi_vld_nxt;
			shift_r <= shift_nxt;
		end
	end

	// Open-drain and pull-up-only pins carry a fixed level
	assign O_SUPPLY_EN = 1'b1;
	assign O_SUPPLY_EN_OE = sup_oe_r;
	assign O_REG_EN = reg_en_r;
	assign O_RXD = rxd_r;
	assign O_RST_LINE = 1'b0;
	assign O_RST_LINE_OE = rst_drv_r;
	assign O_SDO = sdo_r;
	assign O_SDO_OE = sdo_oe_r;
	assign O_SDI_BIT = sdi_r;
	assign O_SDI_VLD = sdi_vld_r;
	assign O_SDO_SHIFT = shift_r;
	assign O_SPI_SEL = sdo_oe_r;
	assign O_MODE = mode_r;
	assign O_WAKE_PEND = wake_r;
endmodule : sprwc_pin_reset_wake

// ==== sprwc_pkg.sv ====
package sprwc_pkg;

	// System clock rate, used to turn times into cycle counts
	localparam int unsigned CLK_MHZ = 250;

	// Reset line hold times in their own units (least values)
	localparam int unsigned COLD_HOLD_US = 20000;
	localparam int unsigned WARM_HOLD_US = 1000;
	// Least low time of a reset pulse from the far side
	localparam int unsigned MIN_RST_PULSE_NS = 15000;

	// Cycle counts; least times round up
	localparam int unsigned COLD_HOLD_CYC = COLD_HOLD_US * CLK_MHZ;
	localparam int unsigned WARM_HOLD_CYC = WARM_HOLD_US * CLK_MHZ;
	localparam int unsigned MIN_RST_CYC = (MIN_RST_PULSE_NS * CLK_MHZ + 999) / 1000;

	// Counter widths: hold timer covers the cold hold, pulse counter the minimum pulse
	localparam int unsigned HOLD_CNT_W = 23;
	localparam int unsigned LOW_CNT_W = 12;
	localparam logic [LOW_CNT_W-1:0] LOW_CNT_TRIP = LOW_CNT_W'(MIN_RST_CYC);

	// Mode request codes from the internal serial register logic
	localparam int unsigned MODE_REQ_W = 2;
	localparam logic [MODE_REQ_W-1:0] REQ_NORMAL = 2'h0;
	localparam logic [MODE_REQ_W-1:0] REQ_SILENT = 2'h1;
	localparam logic [MODE_REQ_W-1:0] REQ_STANDBY = 2'h2;
	localparam logic [MODE_REQ_W-1:0] REQ_SLEEP = 2'h3;

	// Pin synchroniser layout: wake, reset line, chip select, serial clock, serial data
	localparam int unsigned PIN_W = 5;
	localparam int unsigned PIN_WAKE = 0;
	localparam int unsigned PIN_RST = 1;
	localparam int unsigned PIN_CS_N = 2;
	localparam int unsigned PIN_SCLK = 3;
	localparam int unsigned PIN_SDI = 4;
	// Idle levels: reset line and chip select rest high
	localparam logic [PIN_W-1:0] PIN_IDLE = 5'h06;

	// Current mode, one-hot
	typedef enum logic [5:0] {
		MODE_NORMAL = 6'h01,
		MODE_SILENT = 6'h02,
		MODE_STANDBY = 6'h04,
		MODE_SLEEP = 6'h08,
		MODE_RESET = 6'h10,
		MODE_FAILSAFE = 6'h20
	} sprwc_mode_t;

endpackage : sprwc_pkg

// ==== sprwc_tmr_if.sv ====
`timescale 1ns/1ps

// Load and status of the reset hold timer
interface sprwc_tmr_if
	import sprwc_pkg::*;
();
	logic load;
	logic [HOLD_CNT_W-1:0] load_val;
	logic busy;
	logic expire;

	modport ctl (output load, output load_val, input busy, input expire);
	modport tmr (input load, input load_val, output busy, output expire);
endinterface : sprwc_tmr_if

// ==== sprwc_pin_sync.sv ====
`timescale 1ns/1ps

// Two-flop synchroniser per pin plus a third stage for edge detection
module sprwc_pin_sync
	import sprwc_pkg::*;
#(
	parameter int unsigned W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic [W-1:0] i_pin,
	output logic [W-1:0] o_lvl,
	output logic [W-1:0] o_rise,
	output logic [W-1:0] o_fall
);
	logic [W-1:0] ff1_r, ff2_r, ff3_r;
	logic [W-1:0] ff1_nxt, ff2_nxt, ff3_nxt;

	// First stage feeds only the second one
	always_comb begin
		ff1_nxt = i_pin;
		ff2_nxt = ff1_r;
		ff3_nxt = ff2_r;
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			ff1_r <= RST_VAL;
			ff2_r <= RST_VAL;
			ff3_r <= RST_VAL;
		end else begin
			ff1_r <= ff1_nxt;
			ff2_r <= ff2_nxt;
			ff3_r <= ff3_nxt;
		end
	end

	assign o_lvl = ff2_r;
	assign o_rise = ff2_r & ~ff3_r;
	assign o_fall = ~ff2_r & ff3_r;
endmodule : sprwc_pin_sync

// ==== sprwc_hold_tmr.sv ====
`timescale 1ns/1ps

// Down counter that times how long the reset line is held
module sprwc_hold_tmr
	import sprwc_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst,
	sprwc_tmr_if.tmr tif
);
	logic [HOLD_CNT_W-1:0] cnt_r, cnt_nxt;
	logic exp_r, exp_nxt;

	// A load always wins, so a fresh crank cause restarts the full hold
	always_comb begin
		cnt_nxt = cnt_r;
		exp_nxt = 1'b0;
		if (tif.load) begin
			cnt_nxt = tif.load_val;
		end else if (cnt_r != '0) begin
			cnt_nxt = cnt_r - HOLD_CNT_W'(1);
			exp_nxt = (cnt_r == HOLD_CNT_W'(1));
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			cnt_r <= '0;
			exp_r <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			exp_r <= exp_nxt;
		end
	end

	assign tif.busy = (cnt_r != '0);
	assign tif.expire = exp_r;
endmodule : sprwc_hold_tmr

// ==== sprwc_pin_properties.sv ====
`timescale 1ns/1ps

// Pin outputs judged against the current mode and the pin inputs
module sprwc_pin_properties
	import sprwc_pkg::*;
#(
	parameter int unsigned WARM_CYC = 40
) (
	input wire logic I_CLOCK,
	input wire logic I_SYS_RST,
	input wire logic I_WAKE,
	input wire logic I_CS_N,
	input wire logic O_SUPPLY_EN_OE,
	input wire logic O_REG_EN,
	input wire logic O_RXD,
	input wire logic O_RST_LINE_OE,
	input wire logic O_SDO_OE,
	input wire logic O_SDI_VLD,
	input wire logic [5:0] O_MODE,
	input wire logic O_WAKE_PEND
);
	default clocking @(posedge I_CLOCK); endclocking
	default disable iff (I_SYS_RST);
	logic [HOLD_CNT_W-1:0] hold_r;
	logic [HOLD_CNT_W-1:0] hold_nxt;
	// Length of the current pull on the reset line
	always_comb begin
		hold_nxt = (I_SYS_RST || !O_RST_LINE_OE) ? '0 : hold_r + 1'b1;
	end
	always_ff @(posedge I_CLOCK) begin
		hold_r <= hold_nxt;
	end
	sequence s_sleep_edge;
		O_MODE == 6'h08 ##1 $changed(I_WAKE);
	endsequence
	a_reg_by_mode: assert property (
		!$past(I_SYS_RST) |-> O_REG_EN == (O_MODE != 6'h08)) else $error("regulator vs mode");
	a_supply_on_active: assert property (
		!$past(I_SYS_RST) && O_MODE inside {6'h01, 6'h04} |-> O_SUPPLY_EN_OE)
		else $error("supply enable not driven");
	a_supply_off_sleep: assert property (O_MODE == 6'h08 |-> !O_SUPPLY_EN_OE)
		else $error("supply enable driven in sleep");
	a_failsafe_pull: assert property (O_MODE == 6'h20 |-> O_RST_LINE_OE)
		else $error("reset line free in failsafe");
	a_reset_entry_pull: assert property ($rose(O_MODE == 6'h10) |-> O_RST_LINE_OE)
		else $error("reset mode without pull");
	a_wake_rxd_low: assert property (O_WAKE_PEND |-> !O_RXD)
		else $error("receive pin high with wake pending");
	a_sleep_wake_up: assert property (
		s_sleep_edge |-> ##[1:6] (O_MODE == 6'h10 && O_SUPPLY_EN_OE))
		else $error("wake edge not served");
	a_sdo_off_desel: assert property (I_CS_N [*4] |=> !O_SDO_OE)
		else $error("serial output driven while deselected");
	a_sdi_gated: assert property (I_CS_N [*5] |=> !O_SDI_VLD)
		else $error("serial input taken while deselected");
	a_warm_least: assert property ($fell(O_RST_LINE_OE) |-> hold_r >= WARM_CYC)
		else $error("reset pull too short");
endmodule : sprwc_pin_properties

// ==== sprwc_host_model.sv ====
`timescale 1ns/1ps

// Host: serial master with its own clock phase, and a pull on the reset line
module sprwc_host_model (
	input wire logic i_clk,
	input wire logic i_go,
	input wire logic i_sel,
	input wire logic [7:0] i_byte,
	input wire logic i_pull,
	output logic o_cs_n,
	output logic o_sclk,
	output logic o_sdi,
	output logic o_pull_low,
	output logic o_busy
);
	assign o_pull_low = i_pull; // Pull lasts as long as asked
	// Serial clock rests low between frames
	initial begin
		o_cs_n = 1'b1;
		o_sclk = 1'b0;
		o_sdi = 1'b0;
		o_busy = 1'b0;
		forever begin
			@(posedge i_clk);
			if (i_go) begin
				o_busy = 1'b1;
				#7.3 o_cs_n = !i_sel; // Unselected frames toggle clock and data only
				for (int i = 7; i >= 0; i--) begin
					o_sdi = i_byte[i];
					#16 o_sclk = 1'b1; // 32 ns period
					#16 o_sclk = 1'b0;
				end
				#16 o_cs_n = 1'b1;
				o_sdi = !o_sdi; // Released data line keeps no level
				o_busy = 1'b0;
			end
		end
	end
endmodule : sprwc_host_model

// ==== tb.sv ====
`timescale 1ns/1ps

module tb;
	import sprwc_pkg::*;
	localparam int COLD = 200;
	localparam int WARM = 40;
	logic clk, rst, wake, uv, ov, ot, bwake, wdt, rvld, go, sel, pull, sob;
	logic [1:0] req;
	logic [7:0] tx;
	logic cs_n, sclk, sdi, hlow, busy, line, sup, sup_oe, reg_en, rxd, rst_o, rst_oe;
	logic sdo, sdo_oe, sbit, svld, shift, ssel, pend;
	logic [5:0] mode;
	int n_fail, comparisons, cycles;

	assign line = !rst_oe && !hlow; // Pull-up wins when nobody pulls
	sprwc_pin_reset_wake #(.COLD_CYC(COLD), .WARM_CYC(WARM)) dut (
		.I_CLOCK(clk), .I_SYS_RST(rst), .I_WAKE(wake), .I_RST_LINE(line), .I_CS_N(cs_n),
		.I_SCLK(sclk), .I_SDI(sdi), .I_UNDERVOLT(uv), .I_OVERVOLT(ov), .I_OVERTEMP(ot),
		.I_BUS_WAKE(bwake), .I_WDT_ERR(wdt), .I_MODE_REQ_VLD(rvld), .I_MODE_REQ(req),
		.I_BUS_RXD(1'b1), .I_SDO_BIT(sob), .O_SUPPLY_EN(sup), .O_SUPPLY_EN_OE(sup_oe),
		.O_REG_EN(reg_en), .O_RXD(rxd), .O_RST_LINE(rst_o), .O_RST_LINE_OE(rst_oe),
		.O_SDO(sdo), .O_SDO_OE(sdo_oe), .O_SDI_BIT(sbit), .O_SDI_VLD(svld),
		.O_SDO_SHIFT(shift), .O_SPI_SEL(ssel), .O_MODE(mode), .O_WAKE_PEND(pend));
	sprwc_host_model host (.i_clk(clk), .i_go(go), .i_sel(sel), .i_byte(tx), .i_pull(pull),
		.o_cs_n(cs_n), .o_sclk(sclk), .o_sdi(sdi), .o_pull_low(hlow), .o_busy(busy));

	initial begin
		clk = 1'b0;
		forever #2 clk = !clk;
	end
	// Cut a hang short
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			n_fail++;
			complete_run();
		end
	end
	task automatic complete_run();
		if (n_fail == 0 && comparisons > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : complete_run
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_fail++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic step(input int n);
		repeat (n) @(negedge clk);
	endtask : step
	task automatic wait_mode(input logic [5:0] m, input int lim);
		for (int i = 0; i < lim && mode !== m; i++) @(negedge clk);
		chk(8'(mode), 8'(m));
	endtask : wait_mode
	// Counts the pull from now; a margin absorbs the pin synchroniser lag
	task automatic hold_len(input int exp);
		int n;
		n = 0;
		while (rst_oe === 1'b1 && n < 300) begin
			@(negedge clk);
			n++;
		end
		chk(8'(n >= exp - 1 && n <= exp + 4), 8'h01);
	endtask : hold_len
	task automatic req_pulse(input logic [1:0] r);
		@(posedge clk);
		req <= r;
		rvld <= 1'b1;
		@(posedge clk);
		rvld <= 1'b0;
		step(2);
	endtask : req_pulse
	// Power-up cold hold, then the fixed pin levels
	task automatic t_power_up();
		hold_len(COLD);
		wait_mode(6'h04, 10);
		chk({6'h00, sup_oe, reg_en}, 8'h03);
		chk({6'h00, sup, rst_o}, 8'h02);
	endtask : t_power_up
	task automatic t_sleep_wake();
		for (int e = 0; e < 3; e++) begin
			req_pulse(REQ_SLEEP);
			chk({sup_oe, reg_en, mode}, 8'h08);
			@(posedge clk);
			if (e == 2) begin
				bwake <= 1'b1;
			end else begin
				wake <= !wake;
			end
			@(posedge clk);
			bwake <= 1'b0;
			wait_mode(6'h10, 8);
			chk({5'h00, sup_oe, rxd, pend}, 8'h05);
			hold_len(COLD);
			wait_mode(6'h04, 10);
			req_pulse(REQ_NORMAL);
			chk({reg_en, rxd, mode}, 8'hC1);
		end
	endtask : t_sleep_wake
	task automatic t_ext_reset();
		@(posedge clk);
		pull <= 1'b1;
		step(1000);
		@(posedge clk);
		pull <= 1'b0;
		step(10);
		chk(8'(mode), 8'h01);
		@(posedge clk);
		pull <= 1'b1;
		step(3700);
		chk(8'(mode), 8'h01);
		wait_mode(6'h10, 100);
		@(posedge clk);
		pull <= 1'b0;
		hold_len(WARM);
		wait_mode(6'h04, 10);
		@(posedge clk);
		wdt <= 1'b1;
		@(posedge clk);
		wdt <= 1'b0;
		wait_mode(6'h10, 4);
		hold_len(WARM);
		wait_mode(6'h04, 10);
	endtask : t_ext_reset
	// Out bit is high only in selected frames, so a stray shift shows up
	task automatic t_serial(input logic s);
		logic [7:0] got;
		int n;
		int nsh;
		logic seen;
		logic ssn;
		got = 8'h00;
		n = 0;
		nsh = 0;
		seen = 1'b0;
		ssn = 1'b0;
		@(posedge clk);
		sel <= s;
		sob <= s;
		tx <= 8'hA5;
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		for (int k = 0; k < 150 && (busy === 1'b1 || k < 8); k++) begin
			@(negedge clk);
			seen |= sdo_oe;
			ssn |= ssel;
			if (svld === 1'b1) begin
				got = {got[6:0], sbit};
				n++;
			end
			if (shift === 1'b1) begin
				nsh++;
			end
		end
		step(6);
		chk({4'h0, seen, sdo_oe, ssn, ssel}, {4'h0, s, 1'b0, s, 1'b0});
		chk(8'(n), s ? 8'h08 : 8'h00);
		chk(got, s ? 8'hA5 : 8'h00);
		chk(8'(nsh), s ? 8'h08 : 8'h00);
		chk({7'h00, sdo}, 8'h01);
	endtask : t_serial
	task automatic t_faults();
		req_pulse(REQ_SILENT);
		chk(8'(mode), 8'h02);
		@(posedge clk);
		ot <= 1'b1;
		wait_mode(6'h20, 8);
		@(posedge clk);
		ot <= 1'b0;
		wait_mode(6'h10, 8);
		hold_len(COLD);
		wait_mode(6'h04, 10);
		@(posedge clk);
		ov <= 1'b1;
		wait_mode(6'h20, 8);
		req_pulse(REQ_NORMAL);
		chk({line, rst_oe, mode}, 8'h60);
		@(posedge clk);
		ov <= 1'b0;
		wait_mode(6'h10, 8);
		hold_len(COLD);
		wait_mode(6'h04, 10);
		@(posedge clk);
		uv <= 1'b1;
		wait_mode(6'h10, 8);
		@(posedge clk);
		uv <= 1'b0;
		hold_len(COLD);
		wait_mode(6'h04, 10);
	endtask : t_faults
	initial begin
		rst = 1'b1;
		{wake, uv, ov, ot, bwake, wdt, rvld, go, sel, pull, sob} = '0;
		req = 2'h0;
		tx = 8'h00;
		n_fail = 0;
		comparisons = 0;
		cycles = 0;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		step(1);
		t_power_up();
		t_sleep_wake();
		t_ext_reset();
		t_serial(1'b1);
		t_serial(1'b0);
		t_faults();
		complete_run();
	end
endmodule : tb

bind sprwc_pin_reset_wake sprwc_pin_properties #(.WARM_CYC(WARM_CYC)) u_props (
	.I_CLOCK(I_CLOCK), .I_SYS_RST(I_SYS_RST), .I_WAKE(I_WAKE), .I_CS_N(I_CS_N),
	.O_SUPPLY_EN_OE(O_SUPPLY_EN_OE), .O_REG_EN(O_REG_EN), .O_RXD(O_RXD),
	.O_RST_LINE_OE(O_RST_LINE_OE), .O_SDO_OE(O_SDO_OE), .O_SDI_VLD(O_SDI_VLD),
	.O_MODE(O_MODE), .O_WAKE_PEND(O_WAKE_PEND));
